// ==== rtl/fpio_defines.svh ====
// Register indices, field positions and reset values of the port block
`ifndef FPIO_DEFINES_SVH
`define FPIO_DEFINES_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define FPIO_IDX_PORT0      8'h00
`define FPIO_IDX_PORT1      8'h01
`define FPIO_IDX_PORT2      8'h02
`define FPIO_IDX_PORT3      8'h03
`define FPIO_IDX_LO_DIR     8'h10
`define FPIO_IDX_HI_DIR     8'h12
`define FPIO_IDX_HI_PU      8'h22
`define FPIO_IDX_LO_OT      8'h28
`define FPIO_IDX_HI_OT      8'h2A
`define FPIO_IDX_PWM_EN     8'h30
`define FPIO_IDX_MOD_SEL    8'h31
`define FPIO_IDX_ANA_CTL    8'h32
`define FPIO_IDX_NONE       8'hFF

// ---------------------------------------------------------------
// Address and field positions
// ---------------------------------------------------------------
`define FPIO_ADDR_IDX       9:2
`define FPIO_ADDR_HIGH      31:10
`define FPIO_NIB_A          3:0
`define FPIO_NIB_B          7:4
`define FPIO_BYTE           7:0
`define FPIO_ANA_CH         1:0
`define FPIO_ANA_EN         2
`define FPIO_RST_PIN_BIT    12
`define FPIO_RDATA_HIGH     31:8

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define FPIO_RST_BYTE       8'h00
`define FPIO_RST_NIB        4'h0
`define FPIO_RDATA_PAD      24'h00_0000
`define FPIO_HOLD_CNT       16384
`define FPIO_HOLD_W         15
`define FPIO_SYNC_W         13

`endif

// ==== rtl/fpio_pkg.sv ====
// Types used by the port block top module
`default_nettype none
package fpio_pkg;
	typedef logic [3:0] fpio_nib_t;

	typedef struct packed {
		logic [7:0]  dir_lo;
		logic [7:0]  dir_hi;
		logic [7:0]  ot_lo;
		logic [7:0]  ot_hi;
		logic [7:0]  pu_hi;
		fpio_nib_t   latch0;
		fpio_nib_t   latch1;
		fpio_nib_t   latch2;
		fpio_nib_t   pwm_en;
		logic        mod_sel;
		logic [2:0]  ana_ctl;
		logic        ap_wr;
		logic        ap_rd;
		logic [7:0]  ap_idx;
		fpio_nib_t   p0_out;
		fpio_nib_t   p0_oe;
		fpio_nib_t   p1_out;
		fpio_nib_t   p1_oe;
		fpio_nib_t   p2_out;
		fpio_nib_t   p2_oe;
		fpio_nib_t   p2_pu;
		fpio_nib_t   ana_sel;
		logic [31:0] hrdata;
		logic        hready;
		logic        hresp;
	} fpio_state_s;
endpackage
`default_nettype wire

// ==== rtl/fpio_sync_if.sv ====
// Interface between the top and the pin synchroniser
`default_nettype none
`include "fpio_defines.svh"
interface fpio_sync_if;
	logic [`FPIO_SYNC_W-1:0] raw;
	logic [`FPIO_SYNC_W-1:0] stable;
	modport sync (input raw, output stable);
	modport user (output raw, input stable);
endinterface
`default_nettype wire

// ==== rtl/fpio_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`default_nettype none
`include "fpio_defines.svh"
module fpio_sync (
	input  wire logic   clk_in,
	input  wire logic   rstn_in,
	fpio_sync_if.sync   sif
);
	typedef struct packed {
		logic [`FPIO_SYNC_W-1:0] ff1;
		logic [`FPIO_SYNC_W-1:0] ff2;
		logic [`FPIO_SYNC_W-1:0] ff3;
		logic [`FPIO_SYNC_W-1:0] stable;
	} fpio_sync_s;

	fpio_sync_s s_r;
	fpio_sync_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.ff1 = sif.raw;
		s_nxt.ff2 = s_r.ff1;
		s_nxt.ff3 = s_r.ff2;
		// Only the second and third stages are compared
		for (int i = 0; i < `FPIO_SYNC_W; i++) begin
			if (s_r.ff2[i] == s_r.ff3[i]) begin
				s_nxt.stable[i] = s_r.ff3[i];
			end
		end
		if (!rstn_in) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		s_r <= s_nxt;
	end

	assign sif.stable = s_r.stable;
endmodule
`default_nettype wire

// ==== rtl/fpio_hold.sv ====
// Internal reset stretcher after release of the reset pin
`default_nettype none
`include "fpio_defines.svh"
module fpio_hold #(
	parameter int HOLD_CNT = `FPIO_HOLD_CNT
) (
	input  wire logic clk_in,
	input  wire logic rstn_in,
	input  wire logic pin_low_in,
	output logic      busy_out
);
	typedef struct packed {
		logic [`FPIO_HOLD_W-1:0] cnt;
		logic                    busy;
	} fpio_hold_s;

	fpio_hold_s s_r;
	fpio_hold_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!rstn_in || pin_low_in) begin
			s_nxt.cnt  = '0;
			s_nxt.busy = 1'b1;
		end else if (s_r.busy) begin
			if (s_r.cnt == `FPIO_HOLD_W'(HOLD_CNT - 1)) begin
				s_nxt.busy = 1'b0;
			end else begin
				s_nxt.cnt = s_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		s_r <= s_nxt;
	end

	assign busy_out = s_r.busy;

	AST_HOLD_LEN: assert property (@(posedge clk_in)
		disable iff (!rstn_in)
		$fell(s_r.busy) |-> $past(s_r.cnt) == `FPIO_HOLD_W'(HOLD_CNT - 1)
			&& !$past(pin_low_in))
		else $error("internal reset released at wrong count");

	COV_HOLD_DONE: cover property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(s_r.busy));
endmodule
`default_nettype wire

// ==== rtl/fpio_top.sv ====
// Three 4-bit parallel ports with AHB-Lite register access
`default_nettype none
`include "fpio_defines.svh"

module fpio_top
	import fpio_pkg::*;
#(
	parameter int HOLD_CNT = `FPIO_HOLD_CNT
) (
	input  wire logic        ref_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        reset_pin_active_low_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic [3:0]  port0_pin_in,
	output logic      [3:0]  port0_pin_out,
	output logic      [3:0]  port0_oe_out,
	input  wire logic [3:0]  port1_pin_in,
	output logic      [3:0]  port1_pin_out,
	output logic      [3:0]  port1_oe_out,
	input  wire logic [3:0]  port2_pin_in,
	output logic      [3:0]  port2_pin_out,
	output logic      [3:0]  port2_oe_out,
	output logic      [3:0]  port2_pullup_out,
	input  wire logic [1:0]  timer_pwm_in,
	output logic      [3:0]  analog_in_channel_sel_out
);

	// ---------------------------------------------------------------
	// Pin synchronisers and internal reset stretcher
	// ---------------------------------------------------------------
	fpio_sync_if sif ();
	logic        hold_busy;
	logic        rst_int;
	logic [3:0]  pins0;
	logic [3:0]  pins1;
	logic [3:0]  pins2;

	assign sif.raw = {reset_pin_active_low_in, port2_pin_in,
		port1_pin_in, port0_pin_in};
	assign pins0 = sif.stable[3:0];
	assign pins1 = sif.stable[7:4];
	assign pins2 = sif.stable[11:8];

	fpio_sync u_sync (
		.clk_in  (ref_clk_in),
		.rstn_in (rstn_in),
		.sif     (sif)
	);

	fpio_hold #(
		.HOLD_CNT (HOLD_CNT)
	) u_hold (
		.clk_in     (ref_clk_in),
		.rstn_in    (rstn_in),
		.pin_low_in (~sif.stable[`FPIO_RST_PIN_BIT]),
		.busy_out   (hold_busy)
	);

	// Port state follows the stretched reset, not the bare pin
	assign rst_int = ~rstn_in | hold_busy;

	// ---------------------------------------------------------------
	// State and pin drive terms
	// ---------------------------------------------------------------
	fpio_state_s s_r;
	fpio_state_s s_nxt;
	logic        tmr_sel;
	fpio_nib_t   p1_val;
	fpio_nib_t   ana_onehot;
	logic [7:0]  rd_mux;
	logic [7:0]  addr_idx;

	// Modulation source for all PWM channels
	assign tmr_sel = s_r.mod_sel ? timer_pwm_in[1] : timer_pwm_in[0];
	// Disabled channels pass the latch unchanged
	assign p1_val = s_r.latch1 & (~s_r.pwm_en | {4{tmr_sel}});

	always_comb begin
		ana_onehot = `FPIO_RST_NIB;
		ana_onehot[s_r.ana_ctl[`FPIO_ANA_CH]] = s_r.ana_ctl[`FPIO_ANA_EN];
	end

	// Out-of-range addresses map to an index that no register uses
	assign addr_idx = (haddr_in[`FPIO_ADDR_HIGH] == '0)
		? haddr_in[`FPIO_ADDR_IDX] : `FPIO_IDX_NONE;

	// ---------------------------------------------------------------
	// Read multiplexer
	// ---------------------------------------------------------------
	always_comb begin
		case (s_r.ap_idx)
			`FPIO_IDX_PORT0:   rd_mux = {4'h0, pins0};
			`FPIO_IDX_PORT1:   rd_mux = {4'h0, pins1};
			`FPIO_IDX_PORT2:   rd_mux = {4'h0, pins2};
			`FPIO_IDX_LO_DIR:  rd_mux = s_r.dir_lo;
			`FPIO_IDX_HI_DIR:  rd_mux = s_r.dir_hi;
			`FPIO_IDX_HI_PU:   rd_mux = s_r.pu_hi;
			`FPIO_IDX_LO_OT:   rd_mux = s_r.ot_lo;
			`FPIO_IDX_HI_OT:   rd_mux = s_r.ot_hi;
			`FPIO_IDX_PWM_EN:  rd_mux = {4'h0, s_r.pwm_en};
			`FPIO_IDX_MOD_SEL: rd_mux = {7'h00, s_r.mod_sel};
			`FPIO_IDX_ANA_CTL: rd_mux = {5'h00, s_r.ana_ctl};
			default:           rd_mux = `FPIO_RST_BYTE;
		endcase
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.hresp = 1'b0;

		// Write data phase: the low byte, or only its low bits, lands in the addressed register
		if (s_r.ap_wr) begin
			s_nxt.ap_wr = 1'b0;
			case (s_r.ap_idx)
				`FPIO_IDX_PORT0:
					s_nxt.latch0 = hwdata_in[`FPIO_NIB_A];
				`FPIO_IDX_PORT1:
					s_nxt.latch1 = hwdata_in[`FPIO_NIB_A];
				`FPIO_IDX_PORT2:
					s_nxt.latch2 = hwdata_in[`FPIO_NIB_A];
				`FPIO_IDX_LO_DIR:
					s_nxt.dir_lo = hwdata_in[`FPIO_BYTE];
				`FPIO_IDX_HI_DIR:
					s_nxt.dir_hi = hwdata_in[`FPIO_BYTE];
				`FPIO_IDX_HI_PU:
					s_nxt.pu_hi = hwdata_in[`FPIO_BYTE];
				`FPIO_IDX_LO_OT:
					s_nxt.ot_lo = hwdata_in[`FPIO_BYTE];
				`FPIO_IDX_HI_OT:
					s_nxt.ot_hi = hwdata_in[`FPIO_BYTE];
				`FPIO_IDX_PWM_EN:
					s_nxt.pwm_en = hwdata_in[`FPIO_NIB_A];
				`FPIO_IDX_MOD_SEL:
					s_nxt.mod_sel = hwdata_in[0];
				`FPIO_IDX_ANA_CTL:
					s_nxt.ana_ctl = hwdata_in[2:0];
				default: begin
				end
			endcase
		end

		// Read answers one cycle late so a preceding write is visible
		if (s_r.ap_rd) begin
			s_nxt.ap_rd  = 1'b0;
			s_nxt.hready = 1'b1;
			s_nxt.hrdata = {`FPIO_RDATA_PAD, rd_mux};
		end

		// Address phase
		if (hsel_in && htrans_in[1] && hready_in) begin
			s_nxt.ap_idx = addr_idx;
			s_nxt.ap_wr  = hwrite_in;
			s_nxt.ap_rd  = ~hwrite_in;
			if (!hwrite_in) begin
				s_nxt.hready = 1'b0;
			end
		end

		// First port: pull low for zero, release for one
		s_nxt.p0_out = `FPIO_RST_NIB;
		s_nxt.p0_oe  = s_r.dir_lo[`FPIO_NIB_A] & ~s_r.latch0;

		// Open-drain bits drive only when low
		s_nxt.p1_out = p1_val;
		s_nxt.p1_oe  = s_r.dir_lo[`FPIO_NIB_B]
			& (s_r.ot_lo[`FPIO_NIB_B] | ~p1_val);
		s_nxt.p2_out = s_r.latch2;
		s_nxt.p2_oe  = s_r.dir_hi[`FPIO_NIB_A]
			& (s_r.ot_hi[`FPIO_NIB_A] | ~s_r.latch2);
		s_nxt.p2_pu  = s_r.pu_hi[`FPIO_NIB_A];

		// Converter switch closes only on an input pin
		s_nxt.ana_sel = ana_onehot & ~s_r.dir_hi[`FPIO_NIB_A];

		// Stretched reset: all inputs, drivers off, pull-ups off
		if (rst_int) begin
			s_nxt        = '0;
			s_nxt.hready = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		s_r <= s_nxt;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign hrdata_out                = s_r.hrdata;
	assign hreadyout_out             = s_r.hready;
	assign hresp_out                 = s_r.hresp;
	assign port0_pin_out             = s_r.p0_out;
	assign port0_oe_out              = s_r.p0_oe;
	assign port1_pin_out             = s_r.p1_out;
	assign port1_oe_out              = s_r.p1_oe;
	assign port2_pin_out             = s_r.p2_out;
	assign port2_oe_out              = s_r.p2_oe;
	assign port2_pullup_out          = s_r.p2_pu;
	assign analog_in_channel_sel_out = s_r.ana_sel;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_int);

	logic wr_lo_dir;
	assign wr_lo_dir = s_r.ap_wr && s_r.ap_idx == `FPIO_IDX_LO_DIR;

	AST_LO_DIR_WRITE: assert property (
		wr_lo_dir ##2 1'b1 |->
			(port0_oe_out & ~$past(hwdata_in[`FPIO_NIB_A], 2)) == '0)
		else $error("first port drives a bit set as input");

	AST_P0_OPEN_DRAIN: assert property (
		port0_pin_out == '0 &&
		(port0_oe_out & $past(s_r.latch0)) == '0)
		else $error("first port drives high");

	AST_P1_OD_TYPE: assert property (
		(port1_oe_out & port1_pin_out & ~$past(s_r.ot_lo[`FPIO_NIB_B]))
			== '0)
		else $error("open-drain second port bit drives high");

	AST_HI_DIR: assert property (
		(port2_oe_out & ~$past(s_r.dir_hi[`FPIO_NIB_A])) == '0 &&
		(port2_oe_out & port2_pin_out & ~$past(s_r.ot_hi[`FPIO_NIB_A]))
			== '0)
		else $error("third port drive disagrees with direction or type");

	AST_PU_FOLLOW: assert property (
		s_r.ap_wr && s_r.ap_idx == `FPIO_IDX_HI_PU |-> ##2
			port2_pullup_out == $past(hwdata_in[`FPIO_NIB_A], 2))
		else $error("pull-up enables do not follow the register");

	AST_RST_LOW_PORTS: assert property (disable iff (1'b0)
		$fell(rst_int) |-> port0_oe_out == '0 && port1_oe_out == '0)
		else $error("first or second port driving after reset");

	AST_RST_PORT2: assert property (disable iff (1'b0)
		$fell(rst_int) |-> port2_oe_out == '0 && port2_pullup_out == '0)
		else $error("third port not idle after reset");

	AST_PWM_AND: assert property (
		$past(s_r.pwm_en[0]) && !$past(tmr_sel) |-> !port1_pin_out[0])
		else $error("PWM pin high while timer output low");

	AST_ANA_INPUT: assert property (
		(analog_in_channel_sel_out & port2_oe_out) == '0)
		else $error("analog channel selected on a driven pin");

	AST_READ_PIN: assert property (
		s_r.ap_rd && s_r.ap_idx == `FPIO_IDX_PORT0 |=>
			hreadyout_out && hrdata_out[`FPIO_NIB_A] == $past(pins0))
		else $error("port read does not return pin levels");

	// ---------------------------------------------------------------
	// Bus, drive and converter checks
	// ---------------------------------------------------------------
	AST_HRESP_OKAY: assert property (
		hresp_out == 1'b0)
		else $error("slave answered with an error response");

	AST_WR_NO_WAIT: assert property (
		s_r.ap_wr |-> hreadyout_out)
		else $error("write data phase was stretched");

	AST_RD_ONE_WAIT: assert property (
		s_r.ap_rd |-> !hreadyout_out)
		else $error("read answered without its wait state");

	AST_RDATA_PAD: assert property (
		hrdata_out[`FPIO_RDATA_HIGH] == `FPIO_RDATA_PAD)
		else $error("unused read data lanes not zero");

	AST_P0_DIR: assert property (
		(port0_oe_out & ~$past(s_r.dir_lo[`FPIO_NIB_A])) == '0)
		else $error("first port drive without its direction bit");

	AST_P1_DIR: assert property (
		(port1_oe_out & ~$past(s_r.dir_lo[`FPIO_NIB_B])) == '0)
		else $error("second port drives a bit set as input");

	AST_PWM_PASS: assert property (
		$past(s_r.pwm_en[0]) && $past(tmr_sel) |->
			port1_pin_out[0] == $past(s_r.latch1[0]))
		else $error("PWM pin does not follow latch while timer high");

	AST_PWM_OFF: assert property (
		((port1_pin_out ^ $past(s_r.latch1)) & ~$past(s_r.pwm_en)) == '0)
		else $error("plain second port bit differs from its latch");

	AST_ANA_ONEHOT: assert property (
		$onehot0(analog_in_channel_sel_out))
		else $error("more than one converter channel selected");

	AST_ANA_ON: assert property (
		$past(s_r.ana_ctl[`FPIO_ANA_EN]) &&
		$past(s_r.dir_hi[`FPIO_NIB_A]) == '0 |->
			analog_in_channel_sel_out != '0)
		else $error("enabled converter channel not selected");

	AST_P2_OUT: assert property (
		port2_pin_out == $past(s_r.latch2))
		else $error("third port output differs from its latch");

	AST_P2_WRITE: assert property (
		s_r.ap_wr && s_r.ap_idx == `FPIO_IDX_PORT2 |=>
			s_r.latch2 == $past(hwdata_in[`FPIO_NIB_A]))
		else $error("third port latch missed a write");

	COV_READ: cover property (s_r.ap_rd ##1 hreadyout_out);
	COV_PWM: cover property (s_r.pwm_en[0] && port1_oe_out[0]
		##1 port1_pin_out[0] ##1 !port1_pin_out[0]);
	COV_ANA: cover property (analog_in_channel_sel_out != '0);
	COV_OD_RELEASE: cover property (s_r.dir_lo[0] && !port0_oe_out[0]);
endmodule
`default_nettype wire

// ==== testbench/fpio_pin_model.sv ====
// Pin model: resolves pad levels from drivers, pull-ups and outside world
`default_nettype none
module fpio_pin_model (
	input  wire logic [11:0] out_in,
	input  wire logic [11:0] oe_in,
	input  wire logic [3:0]  pu_in,
	input  wire logic [11:0] ext_in,
	output logic      [11:0] lvl_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] pu_all;
	// ---------------------------------------------------------------
	// Pad resolution
	// ---------------------------------------------------------------
	// Only the third port has pull-ups; a driven pad wins over both
	assign pu_all  = {pu_in, 8'h00};
	assign lvl_out = (oe_in & out_in) | (~oe_in & (pu_all | ext_in));
endmodule
`default_nettype wire

// ==== testbench/four_bit_parallel_io_ports_test.sv ====
// Self-checking bench for the three 4-bit ports
`default_nettype none
`include "fpio_defines.svh"
module four_bit_parallel_io_ports_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk;
	logic        rstn;
	logic        rst_pin_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [11:0] pin_out;
	logic [11:0] pin_oe;
	logic [11:0] lvl;
	logic [11:0] ext;
	logic [3:0]  pu;
	logic [1:0]  timer;
	logic [3:0]  ana_sel;
	logic [31:0] rdv;
	int          n_mismatch;
	int          n_compared;
	int          cycles;

	fpio_top #(.HOLD_CNT(16)) u_dut (
		.ref_clk_in              (ref_clk),
		.rstn_in                 (rstn),
		.reset_pin_active_low_in (rst_pin_n),
		.hsel_in                 (hsel),
		.haddr_in                (haddr),
		.htrans_in               (htrans),
		.hwrite_in               (hwrite),
		.hsize_in                (hsize),
		.hwdata_in               (hwdata),
		.hready_in               (hreadyout),
		.hrdata_out              (hrdata),
		.hreadyout_out           (hreadyout),
		.hresp_out               (hresp),
		.port0_pin_in            (lvl[3:0]),
		.port0_pin_out           (pin_out[3:0]),
		.port0_oe_out            (pin_oe[3:0]),
		.port1_pin_in            (lvl[7:4]),
		.port1_pin_out           (pin_out[7:4]),
		.port1_oe_out            (pin_oe[7:4]),
		.port2_pin_in            (lvl[11:8]),
		.port2_pin_out           (pin_out[11:8]),
		.port2_oe_out            (pin_oe[11:8]),
		.port2_pullup_out        (pu),
		.timer_pwm_in            (timer),
		.analog_in_channel_sel_out (ana_sel)
	);

	fpio_pin_model u_pins (
		.out_in  (pin_out),
		.oe_in   (pin_oe),
		.pu_in   (pu),
		.ext_in  (ext),
		.lvl_out (lvl)
	);

	always #10 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Master holds each phase until hready is sampled high
	task automatic bus(input logic [31:0] a, input logic wr,
			input logic [7:0] d);
		@(posedge ref_clk);
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		hsel <= 1'b1;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus({22'h00_0000, idx, 2'b00}, 1'b1, d);
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		bus({22'h00_0000, idx, 2'b00}, 1'b0, 8'h00);
		check(rdv[7:0], exp);
		check(rdv[31:24] | rdv[23:16] | rdv[15:8], 8'h00);
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic test_defaults();
		check(pin_oe[7:0], 8'h00);
		check({pin_oe[11:8], pu}, 8'h00);
		check(ana_sel, 4'h0);
		rd_chk(`FPIO_IDX_LO_DIR, 8'h00);
		rd_chk(`FPIO_IDX_HI_PU, 8'h00);
		check(hresp, 1'b0);
		$display("test_defaults done");
	endtask

	task automatic test_port0();
		ext <= 12'hFFF;
		wr(`FPIO_IDX_PORT0, 8'h03);
		wr(`FPIO_IDX_LO_DIR, 8'h05);
		wr(`FPIO_IDX_LO_OT, 8'h0F);
		cyc(3);
		check(pin_oe[3:0], 4'h4);
		check(pin_out[3:0], 4'h0);
		cyc(6);
		rd_chk(`FPIO_IDX_PORT0, 8'h0B);
		$display("test_port0 done");
	endtask

	task automatic test_port1();
		ext <= 12'h000;
		wr(`FPIO_IDX_PORT1, 8'h06);
		wr(`FPIO_IDX_LO_DIR, 8'hF0);
		wr(`FPIO_IDX_LO_OT, 8'h30);
		cyc(3);
		check(pin_oe[7:4], 4'hB);
		check(pin_out[7:4] & pin_oe[7:4], 4'h2);
		cyc(6);
		rd_chk(`FPIO_IDX_PORT1, 8'h02);
		$display("test_port1 done");
	endtask

	task automatic test_port2();
		wr(`FPIO_IDX_PORT2, 8'h02);
		wr(`FPIO_IDX_HI_PU, 8'h0C);
		wr(`FPIO_IDX_HI_DIR, 8'h03);
		wr(`FPIO_IDX_HI_OT, 8'h01);
		cyc(3);
		check(pin_oe[11:8], 4'h1);
		check(pin_out[8], 1'b0);
		check(pu, 4'hC);
		cyc(6);
		rd_chk(`FPIO_IDX_PORT2, 8'h0C);
		rd_chk(`FPIO_IDX_HI_DIR, 8'h03);
		$display("test_port2 done");
	endtask

	task automatic test_analog();
		wr(`FPIO_IDX_HI_DIR, 8'h00);
		for (int ch = 0; ch < 4; ch++) begin
			wr(`FPIO_IDX_ANA_CTL, 8'h04 | 8'(ch));
			cyc(3);
			check(ana_sel, 4'h1 << ch);
		end
		wr(`FPIO_IDX_HI_DIR, 8'h01);
		wr(`FPIO_IDX_ANA_CTL, 8'h04);
		cyc(3);
		check(ana_sel, 4'h0);
		wr(`FPIO_IDX_ANA_CTL, 8'h01);
		cyc(3);
		check(ana_sel, 4'h0);
		$display("test_analog done");
	endtask

	task automatic test_pwm();
		logic [3:0] exp;
		wr(`FPIO_IDX_LO_OT, 8'hF0);
		wr(`FPIO_IDX_LO_DIR, 8'hF0);
		wr(`FPIO_IDX_PORT1, 8'h05);
		wr(`FPIO_IDX_PWM_EN, 8'h0F);
		for (int s = 0; s < 2; s++) begin
			wr(`FPIO_IDX_MOD_SEL, 8'(s));
			for (int t = 0; t < 4; t++) begin
				timer <= 2'(t);
				cyc(3);
				exp = (t >> s) & 1 ? 4'h5 : 4'h0;
				check(pin_out[7:4], exp);
			end
		end
		timer <= 2'b00;
		wr(`FPIO_IDX_PWM_EN, 8'h00);
		cyc(3);
		check(pin_out[7:4], 4'h5);
		$display("test_pwm done");
	endtask

	task automatic test_refused();
		wr(`FPIO_IDX_PORT3, 8'hFF);
		rd_chk(`FPIO_IDX_PORT3, 8'h00);
		bus(32'h0000_0440, 1'b1, 8'h0F);
		rd_chk(`FPIO_IDX_LO_DIR, 8'hF0);
		bus(32'h0000_0440, 1'b0, 8'h00);
		check(rdv[7:0], 8'h00);
		$display("test_refused done");
	endtask

	task automatic test_reset_pin();
		rst_pin_n <= 1'b0;
		// Sync adds four edges, stretcher and port register one each
		cyc(8);
		check(pin_oe[7:0], 8'h00);
		check(pu, 4'h0);
		rst_pin_n <= 1'b1;
		cyc(3);
		wr(`FPIO_IDX_LO_DIR, 8'h0F);
		cyc(4);
		check(pin_oe[3:0], 4'h0);
		cyc(30);
		rd_chk(`FPIO_IDX_LO_DIR, 8'h00);
		wr(`FPIO_IDX_LO_DIR, 8'h0F);
		cyc(3);
		check(pin_oe[3:0], 4'hF);
		$display("test_reset_pin done");
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		rst_pin_n = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		ext = 12'h000;
		timer = 2'b00;
		n_mismatch = 0;
		n_compared = 0;
		cycles = 0;
		cyc(10);
		rstn <= 1'b1;
		// Internal hold runs HOLD_CNT plus sync edges after release
		cyc(30);
		test_defaults();
		test_port0();
		test_port1();
		test_port2();
		test_analog();
		test_pwm();
		test_refused();
		test_reset_pin();
		give_verdict();
	end
endmodule
`default_nettype wire
